// ==== core/bridge_pwm_pkg.sv ====
// Constants for the full-bridge PWM steering block.
package bridge_pwm_pkg;
    localparam int ADDR_W = 8;
    // Register byte offsets.
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_DUTY_HIGH = 8'h04;
    localparam logic [7:0] OFS_DEADBAND = 8'h08;
    localparam logic [7:0] OFS_PERIOD = 8'h0C;
    localparam logic [7:0] OFS_PORT_LATCH = 8'h10;
    localparam logic [7:0] OFS_DIRECTION = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    // Reset values.
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_DUTY_HIGH = 8'h00;
    localparam logic [6:0] RST_DEADBAND = 7'h00;
    localparam logic [9:0] RST_PERIOD = 10'h0FF;
    localparam logic [3:0] RST_PORT_LATCH = 4'h0;
    localparam logic [3:0] RST_DIRECTION = 4'hF;
    // Control register field positions; PRESC_LSB is the prescale field in the period register.
    localparam int CFG_LSB = 6;
    localparam int DUTY_LOW_LSB = 4;
    localparam int MODE_LSB = 0;
    localparam int PRESC_LSB = 8;
    // Steering configuration codes.
    localparam logic [1:0] STEER_SINGLE = 2'b00;
    localparam logic [1:0] STEER_FULL_FWD = 2'b01;
    localparam logic [1:0] STEER_HALF = 2'b10;
    localparam logic [1:0] STEER_FULL_REV = 2'b11;
    // Mode nibble values 4'hC..4'hF enable PWM; bit 1 inverts A/C, bit 0 inverts B/D.
    localparam logic [1:0] MODE_PWM_HI = 2'b11;
    // Prescale select codes and factors.
    localparam logic [1:0] PRESC_1 = 2'b00;
    localparam logic [1:0] PRESC_4 = 2'b01;
    localparam logic [4:0] PRESC_LIM_1 = 5'h00;
    localparam logic [4:0] PRESC_LIM_4 = 5'h03;
    localparam logic [4:0] PRESC_LIM_16 = 5'h0F;
    // Dead band unit in oscillator periods.
    localparam int DB_UNIT_CYCLES = 4;
endpackage : bridge_pwm_pkg

// ==== core/deadband_delay.sv ====
// Rising-edge delay that forms the half-bridge dead band.
`timescale 1ns/100ps
module deadband_delay
    import bridge_pwm_pkg::*;
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Signal and delay count.
    input wire logic sig_in,
    input wire logic [6:0] count,
    output logic sig_out
);
    logic [8:0] cnt_reg;
    logic [8:0] cnt_next;
    logic out_reg;
    logic out_next;
    logic [8:0] target;
    logic [9:0] hi_run_reg;

    assign target = 9'(count * DB_UNIT_CYCLES);
    assign sig_out = out_reg;

    // Delay rise by four clocks per count.
    always_comb begin
        cnt_next = cnt_reg;
        out_next = out_reg;
        if (!sig_in) begin
            cnt_next = 9'h000;
            out_next = 1'b0;
        end else if (!out_reg) begin
            if (cnt_reg >= target) begin
                out_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 9'h001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 9'h000;
            out_reg <= 1'b0;
            hi_run_reg <= 10'h000;
        end else begin
            cnt_reg <= cnt_next;
            out_reg <= out_next;
            hi_run_reg <= sig_in ? hi_run_reg + 10'h001 : 10'h000;
        end
    end

    a_deadband_rise: assert property (@(posedge pclk) disable iff (!presetn)
        ($rose(out_reg) && $stable(count)) |-> (hi_run_reg == {1'b0, target} + 10'h001))
        else $error("Dead band rise came at the wrong cycle.");
    a_deadband_fall: assert property (@(posedge pclk) disable iff (!presetn)
        !sig_in |=> !out_reg)
        else $error("Dead band output did not fall with its input.");
endmodule : deadband_delay

// ==== core/bridge_pwm.sv ====
// PWM generator with single, half-bridge and full-bridge output steering behind APB.
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/100ps
module bridge_pwm
    import bridge_pwm_pkg::*;
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Bridge pins.
    output logic bridge_out_a,
    output logic bridge_out_b,
    output logic bridge_out_c,
    output logic bridge_out_d,
    output logic pin_oe_a,
    output logic pin_oe_b,
    output logic pin_oe_c,
    output logic pin_oe_d
);
    logic [7:0] ctrl_reg, ctrl_next;
    logic [7:0] duty_reg, duty_next;
    logic [6:0] db_reg, db_next;
    logic [9:0] period_reg, period_next;
    logic [3:0] latch_reg, latch_next;
    logic [3:0] dir_reg, dir_next;
    logic [31:0] prdata_reg, prdata_next;
    logic [4:0] presc_reg, presc_next;
    logic [9:0] fine_reg, fine_next;
    logic pwm_reg, pwm_next;
    logic [3:0] pin_reg, pin_next;
    logic mapped;
    logic wr_en;
    logic [1:0] steer_config;
    logic steer_active;
    logic [9:0] duty10;
    logic [4:0] presc_lim;
    logic [9:0] fine_end;
    logic half_a, half_b;
    logic raw_a, raw_b, raw_c, raw_d;
    logic [3:0] used_mask;
    logic [3:0] steered;

    assign steer_config = ctrl_reg[CFG_LSB +: 2];
    assign steer_active = (ctrl_reg[MODE_LSB+2 +: 2] == MODE_PWM_HI);
    assign duty10 = {duty_reg, ctrl_reg[DUTY_LOW_LSB +: 2]};
    assign fine_end = {period_reg[7:0], 2'b11};

    // APB: one wait-free access; read data is captured in the setup cycle.
    always_comb begin
        if (paddr == OFS_CONTROL) mapped = 1'b1;
        else if (paddr == OFS_DUTY_HIGH) mapped = 1'b1;
        else if (paddr == OFS_DEADBAND) mapped = 1'b1;
        else if (paddr == OFS_PERIOD) mapped = 1'b1;
        else if (paddr == OFS_PORT_LATCH) mapped = 1'b1;
        else if (paddr == OFS_DIRECTION) mapped = 1'b1;
        else if (paddr == OFS_STATUS) mapped = 1'b1;
        else mapped = 1'b0;
    end
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign wr_en = psel && penable && pwrite && mapped;
    assign prdata = prdata_reg;

    always_comb begin
        ctrl_next = ctrl_reg;
        duty_next = duty_reg;
        db_next = db_reg;
        period_next = period_reg;
        latch_next = latch_reg;
        dir_next = dir_reg;
        prdata_next = prdata_reg;
        if (wr_en) begin
            if (paddr == OFS_CONTROL) ctrl_next = pwdata[7:0];
            else if (paddr == OFS_DUTY_HIGH) duty_next = pwdata[7:0];
            else if (paddr == OFS_DEADBAND) db_next = pwdata[6:0];
            else if (paddr == OFS_PERIOD) period_next = pwdata[9:0];
            else if (paddr == OFS_PORT_LATCH) latch_next = pwdata[3:0];
            else if (paddr == OFS_DIRECTION) dir_next = pwdata[3:0];
        end
        if (psel && !penable && !pwrite) begin
            if (paddr == OFS_CONTROL) prdata_next = {24'h000000, ctrl_reg};
            else if (paddr == OFS_DUTY_HIGH) prdata_next = {24'h000000, duty_reg};
            else if (paddr == OFS_DEADBAND) prdata_next = {25'h0, db_reg};
            else if (paddr == OFS_PERIOD) prdata_next = {22'h0, period_reg};
            else if (paddr == OFS_PORT_LATCH) prdata_next = {28'h0000000, latch_reg};
            else if (paddr == OFS_DIRECTION) prdata_next = {28'h0000000, dir_reg};
            else if (paddr == OFS_STATUS) prdata_next = {16'h0000, pin_reg, 1'b0, pwm_reg, fine_reg};
            else prdata_next = 32'h00000000;
        end
    end

    // Prescaled timebase; high while count is below duty.
    always_comb begin
        if (period_reg[PRESC_LSB +: 2] == PRESC_1) presc_lim = PRESC_LIM_1;
        else if (period_reg[PRESC_LSB +: 2] == PRESC_4) presc_lim = PRESC_LIM_4;
        else presc_lim = PRESC_LIM_16;
        presc_next = presc_reg;
        fine_next = fine_reg;
        if (!steer_active) begin
            // Parked on the last tick, so the first enabled cycle opens a full-length count zero.
            presc_next = presc_lim;
            fine_next = fine_end;
        end else if (presc_reg >= presc_lim) begin
            presc_next = 5'h00;
            fine_next = (fine_reg >= fine_end) ? 10'h000 : fine_reg + 10'h001;
        end else begin
            presc_next = presc_reg + 5'h01;
        end
        pwm_next = steer_active && (fine_next < duty10);
    end

    // Complementary half-bridge edges each get the dead band.
    deadband_delay u_db_a (
        .pclk(pclk),
        .presetn(presetn),
        .sig_in(pwm_reg),
        .count(db_reg),
        .sig_out(half_a)
    );
    deadband_delay u_db_b (
        .pclk(pclk),
        .presetn(presetn),
        .sig_in(steer_active && !pwm_reg),
        .count(db_reg),
        .sig_out(half_b)
    );

    // Route the waveform by steering configuration.
    always_comb begin
        raw_a = 1'b0;
        raw_b = 1'b0;
        raw_c = 1'b0;
        raw_d = 1'b0;
        used_mask = 4'h1;
        case (steer_config)
            STEER_SINGLE: begin
                raw_a = pwm_reg;
            end
            STEER_HALF: begin
                raw_a = half_a;
                raw_b = half_b;
                used_mask = 4'h3;
            end
            STEER_FULL_FWD: begin
                raw_a = 1'b1;
                raw_d = pwm_reg;
                used_mask = 4'hF;
            end
            default: begin
                raw_c = 1'b1;
                raw_b = pwm_reg;
                used_mask = 4'hF;
            end
        endcase
        // Mode bit 1 makes A and C active low, bit 0 makes B and D active low.
        steered[0] = raw_a ^ ctrl_reg[MODE_LSB+1];
        steered[1] = raw_b ^ ctrl_reg[MODE_LSB];
        steered[2] = raw_c ^ ctrl_reg[MODE_LSB+1];
        steered[3] = raw_d ^ ctrl_reg[MODE_LSB];
    end

    // Pin multiplexer between PWM and port latch.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pin_next[i] = (steer_active && used_mask[i]) ? steered[i] : latch_reg[i];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= RST_CONTROL;
            duty_reg <= RST_DUTY_HIGH;
            db_reg <= RST_DEADBAND;
            period_reg <= RST_PERIOD;
            latch_reg <= RST_PORT_LATCH;
            dir_reg <= RST_DIRECTION;
            prdata_reg <= 32'h00000000;
            presc_reg <= 5'h00;
            fine_reg <= 10'h000;
            pwm_reg <= 1'b0;
            pin_reg <= 4'h0;
        end else begin
            ctrl_reg <= ctrl_next;
            duty_reg <= duty_next;
            db_reg <= db_next;
            period_reg <= period_next;
            latch_reg <= latch_next;
            dir_reg <= dir_next;
            prdata_reg <= prdata_next;
            presc_reg <= presc_next;
            fine_reg <= fine_next;
            pwm_reg <= pwm_next;
            pin_reg <= pin_next;
        end
    end

    assign bridge_out_a = pin_reg[0];
    assign bridge_out_b = pin_reg[1];
    assign bridge_out_c = pin_reg[2];
    assign bridge_out_d = pin_reg[3];
    // A pin drives only once software has cleared its direction bit.
    assign pin_oe_a = !dir_reg[0];
    assign pin_oe_b = !dir_reg[1];
    assign pin_oe_c = !dir_reg[2];
    assign pin_oe_d = !dir_reg[3];

    // Helper: length of the last high pulse, and whether no write disturbed it.
    logic [15:0] hi_len_reg;
    logic quiet_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_len_reg <= 16'h0000;
            quiet_reg <= 1'b0;
        end else begin
            hi_len_reg <= pwm_reg ? hi_len_reg + 16'h0001 : 16'h0000;
            if (wr_en) quiet_reg <= 1'b0;
            else if (steer_active && presc_reg >= presc_lim && fine_reg >= fine_end) quiet_reg <= 1'b1;
        end
    end

    a_pulse_width: assert property (@(posedge pclk) disable iff (!presetn)
        ($fell(pwm_reg) && quiet_reg && duty10 <= fine_end) |->
        (hi_len_reg == 16'(duty10) * 16'(presc_lim + 5'h01)))
        else $error("PWM pulse width does not match duty times prescale.");
    a_single_route: assert property (@(posedge pclk) disable iff (!presetn)
        (steer_active && steer_config == STEER_SINGLE) |->
        (raw_a == pwm_reg && !raw_b && !raw_c && !raw_d))
        else $error("Single output steering routed wrongly.");
    a_half_compl: assert property (@(posedge pclk) disable iff (!presetn)
        (steer_active && steer_config == STEER_HALF) |-> !(raw_a && raw_b))
        else $error("Half-bridge outputs overlap.");
    a_fwd_levels: assert property (@(posedge pclk) disable iff (!presetn)
        (steer_active && steer_config == STEER_FULL_FWD && $stable(ctrl_reg)) |=>
        (bridge_out_a == !$past(ctrl_reg[1]) && bridge_out_b == $past(ctrl_reg[0]) &&
         bridge_out_c == $past(ctrl_reg[1]) && bridge_out_d == ($past(pwm_reg) ^ $past(ctrl_reg[0]))))
        else $error("Forward full-bridge levels wrong.");
    a_rev_levels: assert property (@(posedge pclk) disable iff (!presetn)
        (steer_active && steer_config == STEER_FULL_REV && $stable(ctrl_reg)) |=>
        (bridge_out_c == !$past(ctrl_reg[1]) && bridge_out_a == $past(ctrl_reg[1]) &&
         bridge_out_d == $past(ctrl_reg[0]) && bridge_out_b == ($past(pwm_reg) ^ $past(ctrl_reg[0]))))
        else $error("Reverse full-bridge levels wrong.");
    a_full_all_pins: assert property (@(posedge pclk) disable iff (!presetn)
        (steer_active && steer_config[0]) |=> (pin_reg == $past(steered)))
        else $error("Full-bridge left a pin to the port latch.");
    a_pin_mux_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !steer_active |=> (pin_reg == $past(latch_reg)))
        else $error("Pins do not follow the port latch while steering is off.");
endmodule : bridge_pwm

// ==== verification/bridge_driver_model.sv ====
// Behavioural model of the power bridge gate drivers on the four steering pins.
`timescale 1ns/100ps
module bridge_driver_model (
    // Clock.
    input wire logic pclk,
    // Pins from the block.
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe,
    // Levels seen at the driver gates.
    output logic [3:0] gate
);
    logic [3:0] float_reg = 4'h5;
    // The gate inputs have no pull, so a released pin wanders instead of keeping its last level.
    always @(posedge pclk) begin
        float_reg <= ~float_reg;
    end
    assign gate = (pin_out & pin_oe) | (float_reg & ~pin_oe);
endmodule : bridge_driver_model

// ==== verification/full_bridge_pwm_steering_test.sv ====
// Self-checking bench for the bridge PWM steering block.
`timescale 1ns/100ps
module full_bridge_pwm_steering_test;
    import bridge_pwm_pkg::*;
    localparam int P = 32;
    localparam int D = 21;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [ADDR_W-1:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] pins;
    logic [3:0] oe;
    logic [3:0] gate;
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;
    int cnt [4];
    always #5 pclk = ~pclk;
    bridge_pwm bridge_pwm_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bridge_out_a(pins[0]), .bridge_out_b(pins[1]), .bridge_out_c(pins[2]), .bridge_out_d(pins[3]),
        .pin_oe_a(oe[0]), .pin_oe_b(oe[1]), .pin_oe_c(oe[2]), .pin_oe_d(oe[3]));
    bridge_driver_model bridge_driver_model_i (.pclk(pclk), .pin_out(pins), .pin_oe(oe), .gate(gate));

    task automatic stop_test();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    // A hung handshake would otherwise stall the run forever.
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            stop_test();
        end
    end

    task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, exp, got);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask : wr

    task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(n, exp, q);
        chk("pslverr", {31'h0, exp_err}, {31'h0, e});
    endtask : rd_chk

    task automatic measure(input int n);
        cnt = '{0, 0, 0, 0};
        repeat (n) begin
            @(negedge pclk);
            for (int i = 0; i < 4; i++) cnt[i] += int'(gate[i]);
        end
    endtask : measure

    // Loads period, dead band and duty, then lets the waveform settle for 256 clocks: two periods at prescale 4, eight at prescale 1.
    task automatic setup(input logic [1:0] presc, input logic [6:0] db, input logic [7:0] ctrl);
        wr(OFS_CONTROL, 32'h0);
        wr(OFS_PERIOD, {22'h0, presc, 8'h07});
        wr(OFS_DEADBAND, {25'h0, db});
        wr(OFS_DUTY_HIGH, 32'(D >> 2));
        wr(OFS_CONTROL, {24'h0, ctrl});
        repeat (2 * P * 4) @(posedge pclk);
    endtask : setup

    task automatic reset_values();
        rd_chk("control", OFS_CONTROL, 32'(RST_CONTROL), 1'b0);
        rd_chk("period", OFS_PERIOD, 32'(RST_PERIOD), 1'b0);
        rd_chk("direction", OFS_DIRECTION, 32'(RST_DIRECTION), 1'b0);
        rd_chk("unmapped", 8'h1C, 32'h0, 1'b1);
        chk("oe after reset", 32'h0, {28'h0, oe});
        wr(OFS_DIRECTION, 32'h0);
        rd_chk("direction", OFS_DIRECTION, 32'h0, 1'b0);
    endtask : reset_values

    task automatic port_latch();
        wr(OFS_PORT_LATCH, 32'hA);
        repeat (2) @(negedge pclk);
        chk("latch on pins", 32'hA, {28'h0, gate});
        wr(OFS_DIRECTION, 32'h3);
        @(negedge pclk);
        chk("oe", 32'hC, {28'h0, oe});
        wr(OFS_DIRECTION, 32'h0);
        wr(OFS_PORT_LATCH, 32'hF);
        repeat (2) @(negedge pclk);
        chk("latch on pins", 32'hF, {28'h0, gate});
    endtask : port_latch

    task automatic single_output(input logic [1:0] presc, input int f);
        setup(presc, 7'h0, {STEER_SINGLE, 2'(D), 4'hC});
        measure(P * f);
        chk("single a high", 32'(D * f), 32'(cnt[0]));
    endtask : single_output

    task automatic half_bridge(input int db);
        setup(PRESC_1, 7'(db), {STEER_HALF, 2'(D), 4'hC});
        measure(P);
        chk("half a high", 32'(D - DB_UNIT_CYCLES * db), 32'(cnt[0]));
        chk("half b high", 32'(P - D - DB_UNIT_CYCLES * db), 32'(cnt[1]));
    endtask : half_bridge

    // The port latch holds all ones here, so a pin left to the latch shows up as a wrong count wherever its expected count is below P.
    task automatic full_bridge(input logic [1:0] steer, input logic [3:0] mode);
        int act;
        int inact;
        int modv;
        act = mode[0] ? 0 : P;
        inact = mode[0] ? P : 0;
        modv = mode[0] ? P - D : D;
        setup(PRESC_1, 7'h0, {steer, 2'(D), mode});
        measure(P);
        chk("full oe", 32'hF, {28'h0, oe});
        if (steer == STEER_FULL_FWD) begin
            chk("fwd a", 32'(act), 32'(cnt[0]));
            chk("fwd b", 32'(inact), 32'(cnt[1]));
            chk("fwd c", 32'(inact), 32'(cnt[2]));
            chk("fwd d", 32'(modv), 32'(cnt[3]));
        end else begin
            chk("rev a", 32'(inact), 32'(cnt[0]));
            chk("rev b", 32'(modv), 32'(cnt[1]));
            chk("rev c", 32'(act), 32'(cnt[2]));
            chk("rev d", 32'(inact), 32'(cnt[3]));
        end
    endtask : full_bridge

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        reset_values();
        port_latch();
        single_output(PRESC_1, 1);
        single_output(PRESC_4, 4);
        half_bridge(1);
        half_bridge(2);
        full_bridge(STEER_FULL_FWD, 4'hC);
        full_bridge(STEER_FULL_REV, 4'hC);
        full_bridge(STEER_FULL_FWD, 4'hF);
        full_bridge(STEER_FULL_REV, 4'hF);
        stop_test();
    end
endmodule : full_bridge_pwm_steering_test
